//--- hdl/rbd_pkg.sv
// package: encodings, phases and constants of the relative branch decoder
`default_nettype none
package rbd_pkg;
  localparam logic [7:0]  OPC_SIGN_SET       = 8'he6;
  localparam logic [7:0]  OPC_CARRY_CLEAR    = 8'he3;
  localparam logic [7:0]  OPC_SIGN_CLEAR     = 8'he7;
  localparam logic [7:0]  OPC_OVERFLOW_CLEAR = 8'he5;
  localparam logic [7:0]  OPC_ZERO_CLEAR     = 8'he1;
  localparam logic [4:0]  OPC_UNCOND_JUMP    = 5'h1a;
  localparam logic [3:0]  OPC_SET_FILE_BIT   = 4'h8;
  localparam logic [20:0] PC_RESET           = 21'h000000;
  localparam logic [20:0] PC_STEP            = 21'h000002;
  localparam logic [15:0] INSN_RESET         = 16'h0000;
  localparam logic [4:0]  FLAGS_RESET        = 5'h00;
  localparam int          FLAG_NEG           = 4;
  localparam int          FLAG_OV            = 3;
  localparam int          FLAG_ZERO          = 2;
  localparam int          FLAG_DC            = 1;
  localparam int          FLAG_CARRY         = 0;
  typedef enum logic [1:0] {
    Q1,
    Q2,
    Q3,
    Q4
  } rbd_phase_type;
endpackage : rbd_pkg
`default_nettype wire

//--- hdl/rbd_target_if.sv
// interface: branch offset request and computed target between modules
`timescale 1ns/1ps
`default_nettype none
interface rbd_target_if;
  logic [20:0] pc;
  logic [10:0] offset;
  logic        wide;
  logic [20:0] target;
  modport core (output pc, output offset, output wide, input target);
  modport calc (input pc, input offset, input wide, output target);
endinterface : rbd_target_if
`default_nettype wire

//--- hdl/rbd_target_calc.sv
// target adder: incremented pc plus twice the sign-extended offset
`timescale 1ns/1ps
`default_nettype none
module rbd_target_calc (
  rbd_target_if.calc tgt
);
  logic [20:0] ext;

  // sign extend either the 8-bit or the 11-bit field
  always_comb begin
    if (tgt.wide) begin
      ext = {{10{tgt.offset[10]}}, tgt.offset};
    end else begin
      ext = {{13{tgt.offset[7]}}, tgt.offset[7:0]};
    end
    tgt.target = tgt.pc + {ext[19:0], 1'b0};
  end
endmodule : rbd_target_calc
`default_nettype wire

//--- hdl/rbd_decoder.sv
// relative branch decoder and executor with q1..q4 phase sequencing
`timescale 1ns/1ps
`default_nettype none
module rbd_decoder (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] insn,
  input  wire logic [4:0]  flags_in,
  input  wire logic [7:0]  file_rdata,
  output var  logic [20:0] pc,
  output var  logic [4:0]  flags,
  output var  logic        fetch,
  output var  logic        nop_cycle,
  output var  logic        file_rd,
  output var  logic        file_wr,
  output var  logic [7:0]  file_addr,
  output var  logic [7:0]  file_wdata
);
  rbd_target_if tgt ();
  rbd_target_calc u_calc (
    .tgt (tgt)
  );

  rbd_pkg::rbd_phase_type phase;
  rbd_pkg::rbd_phase_type next_phase;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic        flush;
  logic        next_flush;
  logic        take;
  logic        next_take;
  logic [20:0] next_pc;
  logic [4:0]  next_flags;
  logic        next_fetch;
  logic        next_nop_cycle;
  logic        next_file_rd;
  logic        next_file_wr;
  logic [7:0]  next_file_addr;
  logic [7:0]  next_file_wdata;
  logic        cond;
  logic        is_branch;
  logic        is_setbit;

  // opcode and offset come from one word
  assign tgt.pc     = pc;
  assign tgt.offset = ir[10:0];
  assign tgt.wide   = (ir[15:11] == rbd_pkg::OPC_UNCOND_JUMP);

  // condition decode; a flushed cycle never branches
  always_comb begin
    cond      = 1'b0;
    is_branch = 1'b1;
    case (ir[15:8])
      rbd_pkg::OPC_SIGN_SET:       cond = flags[rbd_pkg::FLAG_NEG];
      rbd_pkg::OPC_CARRY_CLEAR:    cond = !flags[rbd_pkg::FLAG_CARRY];
      rbd_pkg::OPC_SIGN_CLEAR:     cond = !flags[rbd_pkg::FLAG_NEG];
      rbd_pkg::OPC_OVERFLOW_CLEAR: cond = !flags[rbd_pkg::FLAG_OV];
      rbd_pkg::OPC_ZERO_CLEAR:     cond = !flags[rbd_pkg::FLAG_ZERO];
      default: begin
        cond      = tgt.wide;
        is_branch = tgt.wide;
      end
    endcase
    is_setbit = (ir[15:12] == rbd_pkg::OPC_SET_FILE_BIT) && !flush;
  end

  // phase sequencing, pc update and data register access
  always_comb begin
    next_phase      = phase;
    next_ir         = ir;
    next_flush      = flush;
    next_take       = take;
    next_pc         = pc;
    // flags only follow the core, never a branch
    next_flags      = flags_in;
    next_fetch      = 1'b0;
    next_nop_cycle  = nop_cycle;
    next_file_rd    = 1'b0;
    next_file_wr    = 1'b0;
    next_file_addr  = file_addr;
    next_file_wdata = file_wdata;
    case (phase)
      rbd_pkg::Q1: begin
        next_phase = rbd_pkg::Q2;
        next_take  = 1'b0;
      end
      rbd_pkg::Q2: begin
        next_phase = rbd_pkg::Q3;
        if (is_setbit) begin
          next_file_rd   = 1'b1;
          next_file_addr = ir[7:0];
        end
      end
      rbd_pkg::Q3: begin
        next_phase = rbd_pkg::Q4;
        next_take  = is_branch && cond && !flush;
        if (is_setbit) begin
          next_file_wdata = file_rdata | (8'h01 << ir[11:9]);
        end
      end
      rbd_pkg::Q4: begin
        next_phase = rbd_pkg::Q1;
        next_fetch = 1'b1;
        next_ir    = insn;
        // pc written in q4, then one nop cycle
        if (take) begin
          next_pc        = tgt.target;
          next_flush     = 1'b1;
          next_nop_cycle = 1'b1;
        end else begin
          next_pc        = pc + rbd_pkg::PC_STEP;
          next_flush     = 1'b0;
          next_nop_cycle = 1'b0;
        end
        next_file_wr = is_setbit;
      end
      default: next_phase = rbd_pkg::Q1;
    endcase
  end

  // registers only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase      <= rbd_pkg::Q1;
      ir         <= rbd_pkg::INSN_RESET;
      flush      <= 1'b1;
      take       <= 1'b0;
      pc         <= rbd_pkg::PC_RESET;
      flags      <= rbd_pkg::FLAGS_RESET;
      fetch      <= 1'b0;
      nop_cycle  <= 1'b0;
      file_rd    <= 1'b0;
      file_wr    <= 1'b0;
      file_addr  <= 8'h00;
      file_wdata <= 8'h00;
    end else begin
      phase      <= next_phase;
      ir         <= next_ir;
      flush      <= next_flush;
      take       <= next_take;
      pc         <= next_pc;
      flags      <= next_flags;
      fetch      <= next_fetch;
      nop_cycle  <= next_nop_cycle;
      file_rd    <= next_file_rd;
      file_wr    <= next_file_wr;
      file_addr  <= next_file_addr;
      file_wdata <= next_file_wdata;
    end
  end

  // checks beside the logic
  a_taken_pc_load: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q4 && take) |=> (pc == $past(tgt.target)))
    else $error("taken branch did not load target");
  a_nottaken_step: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q4 && !take) |=> (pc == $past(pc) + rbd_pkg::PC_STEP))
    else $error("untaken pc did not step by one word");
  a_taken_nop: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q4 && take) |=> nop_cycle ##4 !take)
    else $error("no operation cycle missing after taken branch");
  a_sign_set: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q3 && !flush && ir[15:8] == rbd_pkg::OPC_SIGN_SET)
      |=> (take == $past(flags[rbd_pkg::FLAG_NEG])))
    else $error("sign set branch decision wrong");
  a_carry_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q3 && !flush && ir[15:8] == rbd_pkg::OPC_CARRY_CLEAR)
      |=> (take == !$past(flags[rbd_pkg::FLAG_CARRY])))
    else $error("carry clear branch decision wrong");
  a_sign_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q3 && !flush && ir[15:8] == rbd_pkg::OPC_SIGN_CLEAR)
      |=> (take == !$past(flags[rbd_pkg::FLAG_NEG])))
    else $error("sign clear branch decision wrong");
  a_ovf_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q3 && !flush && ir[15:8] == rbd_pkg::OPC_OVERFLOW_CLEAR)
      |=> (take == !$past(flags[rbd_pkg::FLAG_OV])))
    else $error("overflow clear branch decision wrong");
  a_zero_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q3 && !flush && ir[15:8] == rbd_pkg::OPC_ZERO_CLEAR)
      |=> (take == !$past(flags[rbd_pkg::FLAG_ZERO])))
    else $error("zero clear branch decision wrong");
  a_uncond_take: assert property (@(posedge clock) disable iff (!rst_n)
    (phase == rbd_pkg::Q3 && !flush && ir[15:11] == rbd_pkg::OPC_UNCOND_JUMP) |=> take)
    else $error("unconditional jump not taken");
  a_flags_follow: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> (flags == $past(flags_in)))
    else $error("flags altered by decoder");
  a_setbit_write: assert property (@(posedge clock) disable iff (!rst_n)
    file_rd |-> ##2 (file_wr && file_wdata[$past(ir[11:9], 2)]
      && file_addr == $past(ir[7:0], 2)))
    else $error("set bit write missing");
  // a word is only ever loaded as the first phase begins
  a_fetch_q1: assert property (@(posedge clock) disable iff (!rst_n)
    fetch |-> (phase == rbd_pkg::Q1))
    else $error("fetch outside first phase");
  c_taken: cover property (@(posedge clock) phase == rbd_pkg::Q4 && take);
  c_untaken: cover property (@(posedge clock)
    phase == rbd_pkg::Q4 && !take && !flush && ir[15:13] == 3'h7);
  c_uncond: cover property (@(posedge clock) take && tgt.wide);
  c_setbit: cover property (@(posedge clock) file_wr);
endmodule : rbd_decoder
`default_nettype wire

//--- tb/rbd_file_model.sv
// data register file model answering set_file_bit reads
`timescale 1ns/1ps
`default_nettype none
module rbd_file_model (
  input  wire logic       file_rd,
  input  wire logic [7:0] file_addr,
  output var  logic [7:0] file_rdata
);
  // read data answer
  // inverse when idle, so a late sample never matches by luck
  assign file_rdata = file_rd ? (file_addr ^ 8'ha5) : ~(file_addr ^ 8'ha5);
endmodule : rbd_file_model
`default_nettype wire

//--- tb/tb_top.sv
// testbench: random branch stream, expected results queued per cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {
    logic [20:0] pc;
    logic        nop;
    logic [4:0]  flg;
    logic        wr;
    logic [7:0]  adr;
    logic [7:0]  dat;
  } rbd_exp_type;
  logic        clock    = 1'b0;
  logic        rst_n    = 1'b0;
  logic [15:0] insn     = 16'h0000;
  logic [4:0]  flags_in = 5'h00;
  logic [7:0]  file_rdata;
  logic [20:0] pc;
  logic [4:0]  flags;
  logic        fetch;
  logic        nop_cycle;
  logic        file_rd;
  logic        file_wr;
  logic [7:0]  file_addr;
  logic [7:0]  file_wdata;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          seed        = 32'h42e97d06;
  rbd_exp_type exp_q[$];

  always #10 clock = ~clock;

  rbd_decoder uut (.clock(clock), .rst_n(rst_n), .insn(insn), .flags_in(flags_in),
    .file_rdata(file_rdata), .pc(pc), .flags(flags), .fetch(fetch),
    .nop_cycle(nop_cycle), .file_rd(file_rd), .file_wr(file_wr),
    .file_addr(file_addr), .file_wdata(file_wdata));
  rbd_file_model fmod (.file_rd(file_rd), .file_addr(file_addr), .file_rdata(file_rdata));

  task automatic check(input logic [20:0] seen, input logic [20:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // random word; the default arm hits the wide offset extremes
  function automatic logic [15:0] rnd_word();
    logic [31:0] r;
    r = $random(seed);
    case (r[2:0])
      3'h0: rnd_word = {rbd_pkg::OPC_SIGN_SET, r[15:8]};
      3'h1: rnd_word = {rbd_pkg::OPC_CARRY_CLEAR, r[15:8]};
      3'h2: rnd_word = {rbd_pkg::OPC_SIGN_CLEAR, r[15:8]};
      3'h3: rnd_word = {rbd_pkg::OPC_OVERFLOW_CLEAR, r[15:8]};
      3'h4: rnd_word = {rbd_pkg::OPC_ZERO_CLEAR, r[15:8]};
      3'h5: rnd_word = {rbd_pkg::OPC_UNCOND_JUMP, r[18:8]};
      3'h6: rnd_word = {rbd_pkg::OPC_SET_FILE_BIT, r[11:8], r[23:16]};
      default: rnd_word = {rbd_pkg::OPC_UNCOND_JUMP, r[3] ? 11'h3ff : 11'h400};
    endcase
  endfunction : rnd_word

  // branch condition per opcode
  function automatic logic taken_of(input logic [15:0] w, input logic [4:0] f);
    case (w[15:8])
      rbd_pkg::OPC_SIGN_SET: taken_of = f[rbd_pkg::FLAG_NEG];
      rbd_pkg::OPC_CARRY_CLEAR: taken_of = !f[rbd_pkg::FLAG_CARRY];
      rbd_pkg::OPC_SIGN_CLEAR: taken_of = !f[rbd_pkg::FLAG_NEG];
      rbd_pkg::OPC_OVERFLOW_CLEAR: taken_of = !f[rbd_pkg::FLAG_OV];
      rbd_pkg::OPC_ZERO_CLEAR: taken_of = !f[rbd_pkg::FLAG_ZERO];
      default: taken_of = (w[15:11] == rbd_pkg::OPC_UNCOND_JUMP);
    endcase
  endfunction : taken_of

  // twice the sign-extended offset of either form
  function automatic logic [20:0] off2(input logic [15:0] w);
    if (w[15:11] == rbd_pkg::OPC_UNCOND_JUMP) off2 = {{9{w[10]}}, w[10:0], 1'b0};
    else off2 = {{12{w[7]}}, w[7:0], 1'b0};
  endfunction : off2

  // driver: at each fetch, flags for the loaded word and the next word
  initial begin : drive
    logic [15:0] cur;
    logic [20:0] p;
    logic [4:0]  f;
    logic        prv;
    rbd_exp_type e;
    prv  = 1'b0;
    p    = rbd_pkg::PC_RESET + rbd_pkg::PC_STEP;  // flushed cycle after reset steps once
    insn = rnd_word();
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    for (int k = 0; k < 120; k++) begin
      @(negedge clock iff fetch === 1'b1);
      cur   = insn;
      f     = $random(seed);
      e.nop = !prv && taken_of(cur, f);
      e.pc  = e.nop ? p + off2(cur) : p + rbd_pkg::PC_STEP;
      e.flg = f;
      e.wr  = !prv && cur[15:12] == rbd_pkg::OPC_SET_FILE_BIT;
      e.adr = cur[7:0];
      e.dat = (cur[7:0] ^ 8'ha5) | (8'h01 << cur[11:9]);
      exp_q.push_back(e);
      flags_in = f;
      insn     = rnd_word();
      p        = e.pc;
      prv      = e.nop;  // the word after a taken branch is flushed
    end
    repeat (6) @(negedge clock);
    $display("random branch stream done");
    end_of_test();
  end

  // monitor: oldest note against the outputs at each fetch
  always @(posedge clock) begin : watch
    rbd_exp_type e;
    #1;
    if (fetch === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(pc, e.pc);
      check({20'h0, nop_cycle}, {20'h0, e.nop});
      check({16'h0, flags}, {16'h0, e.flg});
      check({20'h0, file_wr}, {20'h0, e.wr});
      if (e.wr) begin
        check({13'h0, file_addr}, {13'h0, e.adr});
        check({13'h0, file_wdata}, {13'h0, e.dat});
      end
    end
  end

  // watchdog sized for the stream plus reset with margin
  initial begin : dog
    #(20 * 4 * 200 + 2000);
    error_cnt++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
